//--- hdl/vrp_regs.vh
// Register map, field positions, reset values and timing for the volt_rms_result/power block
// Overview of operation
// (RQ1) Voltage rms is a filtered mean absolute value, held as unsigned 24 bits.
// (RQ2) Without zero-cross mode the rms result refreshes every five clock cycles.
// (RQ3) Bit 2 of mode_config_two makes the rms result update only at zero crossings.
// (RQ4) Full-scale sine voltage gives an rms result near 0x1CF68C; the code reports the mean absolute value, near 0x517CC1.
// (RQ5) Reported rms is raw rms plus 64 times the signed 12-bit offset trim.
// (RQ6) Voltage times current is low-pass filtered; its dc level is active power.
// (RQ7) Active power is scaled by one plus signed 12-bit gain over 4096.
// (RQ8) Gain 0x7FF adds about half, 0x800 removes half, one step is 0.0244 percent.
// (RQ9) Signed 16-bit power offset is added at 1/256 waveform step resolution.
// (RQ10) With polarity bit clear, a positive-to-negative power change sets status bit 3.
// (RQ11) With polarity bit set, a negative-to-positive change sets that flag instead.
// (RQ12) Enabled sign flag drives the measurement interrupt until the flag is cleared.
// (RQ13) Below the no-load threshold, energy accumulation stops and status bit 0 sets.
// (RQ14) Enabled no-load flag drives the measurement interrupt until the flag is cleared.
// (RQ15) No-load bits 1:0 give off, 0.015, 0.0075 or 0.0037 percent of full scale.
// (RQ16) Status flags stay set until software writes zero to them.
// (RQ17) All trims and comparisons act synchronously, new settings on the next sample; the rms offset trim reaches the rms result at the next rms refresh instead.
`ifndef VRP_REGS_VH
`define VRP_REGS_VH

// Register indices as printed; byte address is four times the index
`define VRP_IDX_MODE_CONFIG_TWO      8'h0C
`define VRP_IDX_NOLOAD     8'h0E
`define VRP_IDX_ACCUM      8'h0F
`define VRP_IDX_PGAIN      8'h1D
`define VRP_IDX_POFFS      8'h20
`define VRP_IDX_IRQEN      8'hD9
`define VRP_IDX_IRQST      8'hDC
`define VRP_IDX_VOLT_RMS_OFFSET_TRIM     8'hE0
`define VRP_IDX_VOLT_RMS_RESULT       8'hE1
`define VRP_IDX_POWER      8'hE2

// Field positions
`define VRP_BIT_RMS_ZERO_CROSS_UPDATE      2
`define VRP_BIT_SIGNPOL    4
`define VRP_BIT_SIGNFLAG   3
`define VRP_BIT_IDLEFLAG   0

// Reset values
`define VRP_RST_8          8'h00
`define VRP_RST_12         12'h000
`define VRP_RST_16         16'h0000
`define VRP_RST_24         24'h000000

// Timing: rms refresh period in clock cycles
`define VRP_RMS_DIV        3'h5

// No-load thresholds on |product| scaled to 24-bit full scale 0x800000
// 0.015%, 0.0075%, 0.0037% of full scale
`define VRP_NL_TH1         24'h0004EA
`define VRP_NL_TH2         24'h000275
`define VRP_NL_TH3         24'h000136

`endif

//--- hdl/vrp_dsp.v
// Voltage rms, active power path with trims, sign and no-load detection
`timescale 1ns/10ps
`include "vrp_regs.vh"

module vrp_dsp #(
	parameter AW = 12,
	parameter SW = 24,
	parameter RMS_SHIFT = 12,
	parameter PWR_SHIFT = 8
) (
	input  wire          clock,
	input  wire          sys_rst,
	input  wire          sample_valid,
	input  wire [SW-1:0] volt_sample,
	input  wire [SW-1:0] curr_sample,
	input  wire [AW-1:0] s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [AW-1:0] s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	output reg           energy_accum_en,
	output reg           measure_irq
);

	// Registers reachable by software
	reg [7:0]    mode_config_two_reg;
	reg [7:0]    no_load_config_reg;
	reg [7:0]    accumulation_config_reg;
	reg [11:0]   power_gain_trim_reg;
	reg [15:0]   power_offset_trim_reg;
	reg [7:0]    measure_irq_enable_low_reg;
	reg [7:0]    measure_irq_status_low_reg;
	reg [11:0]   volt_rms_offset_trim_reg;
	reg [23:0]   volt_rms_result_reg;
	reg [23:0]   power_reg;

	// Datapath state
	reg [47:0]   vabs_lpf_reg;
	reg [55:0]   pwr_lpf_reg;
	reg [2:0]    div_reg;
	reg          volt_sign_reg;
	reg          pwr_sign_reg;
	reg          pwr_seen_reg;

	// Bus holding state
	reg [AW-1:0] aw_addr_reg;
	reg          aw_have_reg;
	reg [31:0]   w_data_reg;
	reg [3:0]    w_strb_reg;
	reg          w_have_reg;

	// Apply byte strobes to a register of up to 32 bits
	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		integer i;
		begin
			merge = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	endfunction

	// Byte address to register index; misaligned gives an unmapped index
	function [7:0] reg_index;
		input [AW-1:0] addr;
		begin
			if (addr[1:0] != 2'h0)
				reg_index = 8'hFF;
			else
				reg_index = addr[9:2];
		end
	endfunction

	// Magnitude of a signed sample
	function [SW-1:0] mag;
		input [SW-1:0] v;
		begin
			mag = v[SW-1] ? (~v + 1'b1) : v;
		end
	endfunction

	// Mean absolute value filter, read out unscaled as the rms result
	// Filter gain is 2^RMS_SHIFT, so the slice below is the dc of |v|
	// Settling takes a few thousand samples at the default shift
	wire [SW-1:0] volt_abs = mag(volt_sample);
	wire [23:0]   rms_raw  = vabs_lpf_reg[RMS_SHIFT +: 24];
	// Raw rms plus 64 x signed offset, clamped to the unsigned range
	wire signed [25:0] rms_sum = $signed({2'b00, rms_raw}) +     // RQ5
		$signed({{8{volt_rms_offset_trim_reg[11]}},
		volt_rms_offset_trim_reg, 6'h00});
	wire [23:0]   rms_corr = rms_sum[25] ? `VRP_RST_24 :
		(rms_sum[24] ? 24'hFFFFFF : rms_sum[23:0]);

	// Product of samples and low-pass for active power
	wire signed [47:0] prod = $signed(volt_sample) *
		$signed(curr_sample);                                      // RQ6
	wire signed [23:0] prod_hi = prod[47:24];
	wire signed [23:0] pwr_raw = pwr_lpf_reg[55:32];
	// Signed view of the power average so its decay term keeps the sign
	wire signed [55:0] pwr_lpf_s   = pwr_lpf_reg;
	wire        [55:0] pwr_lpf_dec = pwr_lpf_s >>> PWR_SHIFT;
	// Gain: p + p*gain/4096, kept in 1/256 steps for the offset stage
	// Extreme gain on a full-scale average can wrap; trims stay small
	wire signed [35:0] gain_prod = pwr_raw *
		$signed(power_gain_trim_reg);                             // RQ7
	wire signed [31:0] pwr_gain = {pwr_raw, 8'h00} +
		gain_prod[35:4];                                         // RQ8
	// Offset in 1/256 steps of the output word
	wire signed [31:0] pwr_full = pwr_gain +
		{{16{power_offset_trim_reg[15]}}, power_offset_trim_reg}; // RQ9
	wire signed [23:0] pwr_word = pwr_full[31:8];

	// No-load threshold select on the multiplier output magnitude
	reg  [23:0] nl_th;
	always @* begin
		case (no_load_config_reg[1:0])                            // RQ15
		2'h1:    nl_th = `VRP_NL_TH1;
		2'h2:    nl_th = `VRP_NL_TH2;
		2'h3:    nl_th = `VRP_NL_TH3;
		default: nl_th = `VRP_RST_24;
		endcase
	end
	wire [23:0] prod_mag = mag(prod_hi);
	wire        no_load  = (no_load_config_reg[1:0] != 2'h0) &&
		(prod_mag < nl_th);
	// Zero crossing: sign of this voltage sample differs from the last
	// Sign change of power: zero words neither arm nor fire the detector
	wire        zx_now   = sample_valid &&
		(volt_sample[SW-1] != volt_sign_reg);
	wire        new_sign = pwr_word[23];
	wire        sign_ev  = sample_valid && pwr_seen_reg &&
		(pwr_word != 24'h000000) && (new_sign != pwr_sign_reg) &&
		(accumulation_config_reg[`VRP_BIT_SIGNPOL] ? ~new_sign :  // RQ11
		new_sign);                                               // RQ10
	wire        rms_tick = (div_reg == `VRP_RMS_DIV - 3'h1);
	// Which event refreshes the rms result
	wire        rms_load = mode_config_two_reg[`VRP_BIT_RMS_ZERO_CROSS_UPDATE] ?
		zx_now : rms_tick;                                       // RQ3 RQ2

	// Write path decode
	wire        wr_go  = aw_have_reg && w_have_reg && !s_axi_bvalid;
	wire [7:0]  wr_idx = reg_index(aw_addr_reg);
	wire        wr_st  = wr_go && (wr_idx == `VRP_IDX_IRQST);

	// Software clear of a flag: lane 0 strobed with a zero in its bit
	wire        clr_sign = wr_st && w_strb_reg[0] &&
		!w_data_reg[`VRP_BIT_SIGNFLAG];
	wire        clr_idle = wr_st && w_strb_reg[0] &&
		!w_data_reg[`VRP_BIT_IDLEFLAG];
	// Hardware events that raise the sticky flags
	wire        set_sign = sign_ev;
	wire        set_idle = sample_valid && no_load;

	// Held write data merged by byte lane into each writable register
	wire [31:0] mrg_mode  = merge({24'h0, mode_config_two_reg},
		w_data_reg, w_strb_reg);
	wire [31:0] mrg_nload = merge({24'h0, no_load_config_reg},
		w_data_reg, w_strb_reg);
	wire [31:0] mrg_accum = merge({24'h0, accumulation_config_reg},
		w_data_reg, w_strb_reg);
	wire [31:0] mrg_gain  = merge({20'h0, power_gain_trim_reg},
		w_data_reg, w_strb_reg);
	wire [31:0] mrg_poffs = merge({16'h0, power_offset_trim_reg},
		w_data_reg, w_strb_reg);
	wire [31:0] mrg_irqen = merge({24'h0, measure_irq_enable_low_reg},
		w_data_reg, w_strb_reg);
	wire [31:0] mrg_vofs  = merge({20'h0, volt_rms_offset_trim_reg},
		w_data_reg, w_strb_reg);

	// Signal path registers, all synchronous to the clock
	// Filters move only on sample_valid; the rms divider runs freely
	// so the refresh rate does not depend on the sample rate
	always @(posedge clock) begin
		if (sys_rst) begin
			vabs_lpf_reg        <= 48'h0;
			pwr_lpf_reg         <= 56'h0;
			div_reg             <= 3'h0;
			volt_sign_reg       <= 1'b0;
			pwr_sign_reg        <= 1'b0;
			pwr_seen_reg        <= 1'b0;
			volt_rms_result_reg <= `VRP_RST_24;
			power_reg           <= `VRP_RST_24;
			energy_accum_en     <= 1'b0;
		end else begin
			div_reg <= rms_tick ? 3'h0 : div_reg + 3'h1;
			if (sample_valid) begin                               // RQ17
				vabs_lpf_reg <= vabs_lpf_reg - (vabs_lpf_reg >> RMS_SHIFT) +
					{24'h0, volt_abs};                               // RQ1
				pwr_lpf_reg <= pwr_lpf_reg - pwr_lpf_dec +
					{{8{prod[47]}}, prod};
				volt_sign_reg   <= volt_sample[SW-1];
				power_reg       <= pwr_word;
				energy_accum_en <= !no_load;                          // RQ13
				if (pwr_word != 24'h000000) begin
					pwr_sign_reg <= new_sign;
					pwr_seen_reg <= 1'b1;
				end
			end
			// Refresh rms on the divider or only at voltage zero crossings
			if (rms_load)
				volt_rms_result_reg <= rms_corr;                     // RQ4
		end
	end

	// Software registers and sticky status; hardware set beats clear
	always @(posedge clock) begin
		if (sys_rst) begin
			mode_config_two_reg        <= `VRP_RST_8;
			no_load_config_reg         <= `VRP_RST_8;
			accumulation_config_reg    <= `VRP_RST_8;
			power_gain_trim_reg        <= `VRP_RST_12;
			power_offset_trim_reg      <= `VRP_RST_16;
			measure_irq_enable_low_reg <= `VRP_RST_8;
			measure_irq_status_low_reg <= `VRP_RST_8;
			volt_rms_offset_trim_reg   <= `VRP_RST_12;
			measure_irq                <= 1'b0;
		end else begin
			if (wr_go) begin
				case (wr_idx)
				`VRP_IDX_MODE_CONFIG_TWO:  mode_config_two_reg <=
					mrg_mode[7:0];
				`VRP_IDX_NOLOAD: no_load_config_reg <=
					mrg_nload[7:0];
				`VRP_IDX_ACCUM:  accumulation_config_reg <=
					mrg_accum[7:0];
				`VRP_IDX_PGAIN:  power_gain_trim_reg <=
					mrg_gain[11:0];
				`VRP_IDX_POFFS:  power_offset_trim_reg <=
					mrg_poffs[15:0];
				`VRP_IDX_IRQEN:  measure_irq_enable_low_reg <=
					mrg_irqen[7:0];
				`VRP_IDX_VOLT_RMS_OFFSET_TRIM: volt_rms_offset_trim_reg <=
					mrg_vofs[11:0];
				default: ;
				endcase
			end
			// Zero written to a flag clears it unless its event coincides
			measure_irq_status_low_reg[`VRP_BIT_SIGNFLAG] <=
				set_sign ||                                          // RQ10
				(measure_irq_status_low_reg[`VRP_BIT_SIGNFLAG] &&
				!clr_sign);                                          // RQ16
			measure_irq_status_low_reg[`VRP_BIT_IDLEFLAG] <=
				set_idle ||                                          // RQ13
				(measure_irq_status_low_reg[`VRP_BIT_IDLEFLAG] &&
				!clr_idle);                                          // RQ16
			// Level interrupt while any enabled flag stands
			measure_irq <= |(measure_irq_status_low_reg &
				measure_irq_enable_low_reg &
				8'h09);                                             // RQ12 RQ14
		end
	end

	// AXI4-Lite write channel: address and data taken in either order
	// Each ready pulses for one cycle while its holding slot is empty
	// The register is written one cycle after both halves are held
	// and bvalid rises on that same edge, staying until bready
	// No new address or data is taken while a response waits
	always @(posedge clock) begin
		if (sys_rst) begin
			aw_addr_reg   <= {AW{1'b0}};
			aw_have_reg   <= 1'b0;
			w_data_reg    <= 32'h0;
			w_strb_reg    <= 4'h0;
			w_have_reg    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_have_reg <= 1'b1;
			end
			if (wr_go) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (wr_idx)
				`VRP_IDX_MODE_CONFIG_TWO, `VRP_IDX_NOLOAD, `VRP_IDX_ACCUM,
				`VRP_IDX_PGAIN, `VRP_IDX_POFFS, `VRP_IDX_IRQEN,
				`VRP_IDX_IRQST, `VRP_IDX_VOLT_RMS_OFFSET_TRIM:
					s_axi_bresp <= 2'h0;
				default: s_axi_bresp <= 2'h2;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	// arready pulses one cycle after arvalid is seen with no answer out
	// Data and code are latched at the address handshake and held
	// until rready; unmapped indices answer zero with an error code
	always @(posedge clock) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				case (reg_index(s_axi_araddr))
				`VRP_IDX_MODE_CONFIG_TWO:  s_axi_rdata <= {24'h0, mode_config_two_reg};
				`VRP_IDX_NOLOAD: s_axi_rdata <= {24'h0, no_load_config_reg};
				`VRP_IDX_ACCUM:  s_axi_rdata <=
					{24'h0, accumulation_config_reg};
				`VRP_IDX_PGAIN:  s_axi_rdata <= {20'h0, power_gain_trim_reg};
				`VRP_IDX_POFFS:  s_axi_rdata <= {16'h0, power_offset_trim_reg};
				`VRP_IDX_IRQEN:  s_axi_rdata <=
					{24'h0, measure_irq_enable_low_reg};
				`VRP_IDX_IRQST:  s_axi_rdata <=
					{24'h0, measure_irq_status_low_reg};
				`VRP_IDX_VOLT_RMS_OFFSET_TRIM: s_axi_rdata <=
					{20'h0, volt_rms_offset_trim_reg};
				`VRP_IDX_VOLT_RMS_RESULT:   s_axi_rdata <= {8'h0, volt_rms_result_reg};
				`VRP_IDX_POWER:  s_axi_rdata <= {8'h0, power_reg};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

//--- sim/vrp_dsp_assertions.sv
// Port timing checks for the volt_rms_result and active power block
`timescale 1ns/10ps
module vrp_dsp_chk (
	input wire        clock,
	input wire        sys_rst,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// Handshake pulses, answers and holding of responses
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready longer than one cycle");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped before bready");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read answer late");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_resp_code: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
		else $error("illegal write response code");
endmodule

bind vrp_dsp vrp_dsp_chk vrp_dsp_chk_i (.clock, .sys_rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready);

//--- sim/vrp_dsp_tb.sv
// Self-checking bench for the volt_rms_result and active power block
`timescale 1ns/10ps
module vrp_dsp_tb;
	reg         clock = 1'b0;
	reg         sys_rst = 1'b1;
	reg         sample_valid = 1'b1;
	reg  [23:0] volt_sample = 24'h000000;
	reg  [23:0] curr_sample = 24'h000000;
	reg  [11:0] s_axi_awaddr = 12'h000;
	reg         s_axi_awvalid = 1'b0;
	reg  [31:0] s_axi_wdata = 32'h00000000;
	reg  [3:0]  s_axi_wstrb = 4'hF;
	reg         s_axi_wvalid = 1'b0;
	reg         s_axi_bready = 1'b0;
	reg  [11:0] s_axi_araddr = 12'h000;
	reg         s_axi_arvalid = 1'b0;
	reg         s_axi_rready = 1'b0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire        s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        energy_accum_en, measure_irq;
	integer     err_count = 0;
	integer     checks = 0;
	integer     cycles = 0;
	integer     seed = 89278;
	integer     mdl [0:6];
	integer     t;
	reg  [31:0] got, d;
	reg  [1:0]  resp;
	// Writable register indices and their implemented widths
	reg  [7:0]  idx [0:6] = '{8'h0C, 8'h0E, 8'h0F, 8'h1D, 8'h20, 8'hD9, 8'hE0};
	reg  [15:0] msk [0:6] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h0FFF,
		16'hFFFF, 16'h00FF, 16'h0FFF};

	vrp_dsp vrp_dsp_i (.clock, .sys_rst, .sample_valid, .volt_sample,
		.curr_sample, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .energy_accum_en, .measure_irq);

	initial begin
		forever #12.5 clock = ~clock;
	end

	task automatic chk(input [31:0] g, input [31:0] e);
		checks = checks + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	// Bus write by register index; bready stays up until bvalid
	task automatic wr(input [7:0] i, input [31:0] v);
		@(posedge clock);
		s_axi_awaddr <= {2'b00, i, 2'b00};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Bus read by register index
	task automatic rd(input [7:0] i);
		@(posedge clock);
		s_axi_araddr <= {2'b00, i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		got = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic idle(input integer n);
		repeat (n) @(posedge clock);
	endtask

	// Wait for the interrupt line, bounded
	task automatic wait_irq;
		integer n;
		n = 0;
		while (measure_irq !== 1'b1 && n < 20000) begin
			@(posedge clock);
			n = n + 1;
		end
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Cuts a hang short
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 90000) begin
			err_count = err_count + 1;
			tally_and_finish;
		end
	end

	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		for (int k = 0; k < 7; k++) begin
			rd(idx[k]);
			chk(got, 32'h0);
			d = $random(seed);
			wr(idx[k], d);
			mdl[k] = d & msk[k];
		end
		for (int k = 0; k < 7; k++) begin
			rd(idx[k]);
			chk(got, mdl[k]);
		end
		rd(8'h01);
		chk(resp, 2'h2);
		chk(got, 32'h0);
		wr(8'h01, 32'h5A);
		chk(resp, 2'h2);
		$display("test registers done");
		wr(8'h0C, 32'h0);
		foreach (mdl[k]) begin
			t = (k == 0) ? 16 : (k == 1) ? -1 : 2047;
			wr(8'hE0, t & 32'hFFF);
			idle(8);
			rd(8'hE1);
			chk(got, (t < 0) ? 0 : t * 64);
		end
		wr(8'h0C, 32'h4);
		wr(8'hE0, 32'h10);
		idle(20);
		rd(8'hE1);
		chk(got, 32'h1FFC0);
		wr(8'h0C, 32'h0);
		idle(8);
		rd(8'hE1);
		chk(got, 32'h400);
		$display("test rms done");
		wr(8'h1D, 32'h0);
		wr(8'h20, 32'h0500);
		idle(8);
		rd(8'hE2);
		chk(got, 32'h5);
		wr(8'h20, 32'hFB00);
		idle(8);
		rd(8'hE2);
		chk(got, 32'hFFFFFB);
		$display("test power offset done");
		wr(8'hD9, 32'h01);
		for (int m = 1; m < 4; m++) begin
			wr(8'h0E, m);
			idle(4);
			chk(energy_accum_en, 1'b0);
			rd(8'hDC);
			chk(got & 32'h1, 32'h1);
			chk(measure_irq, 1'b1);
		end
		wr(8'h0E, 32'h0);
		wr(8'hDC, 32'h0);
		idle(4);
		rd(8'hDC);
		chk(got, 32'h0);
		chk(measure_irq, 1'b0);
		chk(energy_accum_en, 1'b1);
		$display("test no load done");
		wr(8'h0F, 32'h0);
		wr(8'h20, 32'h0);
		wr(8'hD9, 32'h08);
		volt_sample <= 24'h400000;
		curr_sample <= 24'h400000;
		idle(3000);
		wr(8'hDC, 32'h0);
		curr_sample <= 24'hC00000;
		wait_irq;
		rd(8'hDC);
		chk(got, 32'h8);
		chk(measure_irq, 1'b1);
		s_axi_wstrb <= 4'h2;
		wr(8'hDC, 32'h0);
		s_axi_wstrb <= 4'hF;
		idle(4);
		chk(measure_irq, 1'b1);
		wr(8'hDC, 32'h0);
		idle(4);
		chk(measure_irq, 1'b0);
		wr(8'h0F, 32'h10);
		curr_sample <= 24'h400000;
		wait_irq;
		rd(8'hDC);
		chk(got, 32'h8);
		$display("test sign done");
		tally_and_finish;
	end
endmodule
